// [rtl/eirq_ctrl.sv]
// Purpose: external interrupt pin, keyboard merge and reset pin logic
// Assumes: apb slave, zero wait states, pin inputs synchronous to clk
// Notes:   level requests also reach cpu_irq combinationally
`timescale 1ns/1ps
`include "eirq_defines.svh"

// How it works
// - with the sensitivity bit set the low interrupt pin reaches the cpu request through a path that needs no clock edge.
// - with the sensitivity bit clear only a falling edge requests, with it set a low level requests too.
// - with the merge bit set the four keyboard pins are ORed into the same request.
// - keyboard pins are active high, so a rising edge or a high level counts as an event.
// - the edge or level choice applies equally to the interrupt pin and the keyboard pins.
// - an outside party holding the reset pin low keeps the device in reset.
// - the device drives the reset pin low while a watchdog, illegal address or low voltage reset acts.
// - the request has a software readable flag and a software mask that blocks cpu delivery.
module eirq_ctrl
  import eirq_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`EIRQ_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // interrupt pins
  input  wire logic                        irq_pin_n,
  input  wire logic [`EIRQ_KBD_W-1:0]      keyboard_irq_pins,
  // reset pin, open drain
  input  wire logic                        reset_pin_in,
  output logic                             reset_pin_out,
  output logic                             reset_pin_oe_n,
  // internal reset causes
  input  wire eirq_rst_src_s               rst_src,
  // cpu side
  output logic                             cpu_irq,
  output logic                             core_reset
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  eirq_opt_s               option_config_register;
  eirq_opt_s               next_option_config_register;
  logic                    irq_mask;
  logic                    next_irq_mask;
  logic                    req_flag;
  logic                    next_req_flag;
  eirq_pins_s              sync1;
  eirq_pins_s              sync2;
  eirq_pins_s              prev;
  logic [31:0]             next_prdata;
  logic                    drive_low;
  logic                    next_drive_low;
  logic                    local_rst;
  logic                    wr_access;
  logic                    rd_setup;
  logic                    edge_evt;
  logic                    level_evt;
  logic                    ack;

  function automatic logic addr_mapped(input logic [`EIRQ_ADDR_W-1:0] a);
    addr_mapped = (a == `EIRQ_OFS_OPTION) || (a == `EIRQ_OFS_CTRL);
  endfunction

  // ----------------------------------------------------------------------
  // reset pin
  // ----------------------------------------------------------------------
  assign local_rst      = rst | ~reset_pin_in;
  assign core_reset     = local_rst;
  assign next_drive_low = |rst_src;
  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe_n = ~(drive_low | next_drive_low);

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= next_drive_low;
    end
  end

  // ----------------------------------------------------------------------
  // pin synchroniser and event detect
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (local_rst) begin
      sync1 <= '{irq_n: 1'b1, kbd: `EIRQ_KBD_IDLE};
      sync2 <= '{irq_n: 1'b1, kbd: `EIRQ_KBD_IDLE};
      prev  <= '{irq_n: 1'b1, kbd: `EIRQ_KBD_IDLE};
    end else begin
      sync1 <= '{irq_n: irq_pin_n, kbd: keyboard_irq_pins};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  always_comb begin
    edge_evt  = (prev.irq_n & ~sync2.irq_n)
              | (option_config_register.port_irq_merge_enable
                 & |(~prev.kbd & sync2.kbd));
    level_evt = option_config_register.level_sense
              & (~sync2.irq_n
                 | (option_config_register.port_irq_merge_enable
                    & |sync2.kbd));
  end

  // ----------------------------------------------------------------------
  // request output
  // ----------------------------------------------------------------------
  always_comb begin
    cpu_irq = ~irq_mask
            & (req_flag
               | (option_config_register.level_sense
                  & (~irq_pin_n
                     | (option_config_register.port_irq_merge_enable
                        & |keyboard_irq_pins))));
  end

  // ----------------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------------
  assign pready    = 1'b1;
  assign wr_access = psel & penable & pwrite & addr_mapped(paddr);
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign ack       = wr_access && paddr == `EIRQ_OFS_CTRL
                     && pwdata[`EIRQ_CTRL_ACK_BIT];

  always_comb begin
    pslverr                     = psel & penable & ~addr_mapped(paddr);
    next_option_config_register = option_config_register;
    next_irq_mask               = irq_mask;
    next_prdata                 = prdata;
    if (wr_access && paddr == `EIRQ_OFS_OPTION) begin
      next_option_config_register.level_sense           = pwdata[`EIRQ_OPT_LEVEL_BIT];
      next_option_config_register.port_irq_merge_enable = pwdata[`EIRQ_OPT_MERGE_BIT];
    end else if (wr_access && paddr == `EIRQ_OFS_CTRL) begin
      next_irq_mask = pwdata[`EIRQ_CTRL_MASK_BIT];
    end
    // set wins over acknowledge
    next_req_flag = ((req_flag & ~ack) | edge_evt | level_evt);
    if (rd_setup) begin
      next_prdata = 32'h0;
      if (paddr == `EIRQ_OFS_OPTION) begin
        next_prdata[`EIRQ_OPT_LEVEL_BIT] = option_config_register.level_sense;
        next_prdata[`EIRQ_OPT_MERGE_BIT] = option_config_register.port_irq_merge_enable;
      end else if (paddr == `EIRQ_OFS_CTRL) begin
        next_prdata[`EIRQ_CTRL_MASK_BIT] = irq_mask;
        next_prdata[`EIRQ_CTRL_REQ_BIT]  = req_flag;
        next_prdata[`EIRQ_CTRL_PIN_BIT]  = sync2.irq_n;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (local_rst) begin
      option_config_register <= `EIRQ_OPT_RESET;
      irq_mask               <= `EIRQ_MASK_RESET;
      req_flag               <= 1'b0;
      prdata                 <= 32'h0;
    end else begin
      option_config_register <= next_option_config_register;
      irq_mask               <= next_irq_mask;
      req_flag               <= next_req_flag;
      prdata                 <= next_prdata;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (local_rst);

  a_irq_fall_sets: assert property (
    ##1 ($fell(sync2.irq_n)) |=> req_flag)
    else $error("falling irq pin did not set request flag");

  a_kbd_rise_sets: assert property (
    ##1 (option_config_register.port_irq_merge_enable && $rose(sync2.kbd[0]))
    |=> req_flag)
    else $error("merged keyboard rise did not set request flag");

  a_kbd_unmerged: assert property (
    (!option_config_register.port_irq_merge_enable && !req_flag
     && !level_evt && prev.irq_n == sync2.irq_n && !ack) |=> !req_flag)
    else $error("unmerged keyboard line raised request");

  a_level_holds: assert property (
    (option_config_register.level_sense && !sync2.irq_n) [*2] |-> req_flag ##1 req_flag)
    else $error("low level in level mode did not hold request");

  a_async_path: assert property (
    (!irq_mask && option_config_register.level_sense && !irq_pin_n) |-> cpu_irq)
    else $error("low irq pin did not reach cpu without a clock edge");

  a_mask_blocks: assert property (
    irq_mask |-> !cpu_irq)
    else $error("masked request reached cpu");

  a_ack_clears: assert property (
    (ack && !edge_evt && !level_evt) |=> !req_flag)
    else $error("acknowledge did not clear request flag");

  a_pin_resets: assert property (
    disable iff (rst) !reset_pin_in |-> core_reset
    ##1 (option_config_register == `EIRQ_OPT_RESET && !req_flag && !irq_mask))
    else $error("low reset pin did not reset core");

  a_drive_low: assert property (
    disable iff (rst) (|rst_src) |-> !reset_pin_oe_n ##1 !reset_pin_oe_n)
    else $error("internal reset did not pull reset pin low");

  c_edge_irq:  cover property ($fell(sync2.irq_n) ##1 req_flag ##[1:20] ack);
  c_kbd_merge: cover property (option_config_register.port_irq_merge_enable
                               && $rose(sync2.kbd[2]) ##2 cpu_irq);
  c_set_on_ack: cover property (ack && edge_evt);
  c_int_reset: cover property (disable iff (rst) rst_src.watchdog_timeout);

endmodule // eirq_ctrl

// [rtl/eirq_defines.svh]
// Purpose: named constants of the external interrupt and reset pin block
// Assumes: 32-bit apb, byte addresses, one aligned word per register
// Notes:   included by the package and the design module
`ifndef EIRQ_DEFINES_SVH
`define EIRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define EIRQ_ADDR_W         8
`define EIRQ_OFS_OPTION     8'h00
`define EIRQ_OFS_CTRL       8'h04

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EIRQ_OPT_LEVEL_BIT  0
`define EIRQ_OPT_MERGE_BIT  1
`define EIRQ_CTRL_MASK_BIT  0
`define EIRQ_CTRL_ACK_BIT   1
`define EIRQ_CTRL_REQ_BIT   2
`define EIRQ_CTRL_PIN_BIT   3

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define EIRQ_KBD_W          4
`define EIRQ_OPT_RESET      2'h0
`define EIRQ_MASK_RESET     1'h0
`define EIRQ_KBD_IDLE       4'h0

`endif

// [rtl/eirq_pkg.sv]
// Purpose: types of the external interrupt and reset pin block
// Assumes: eirq_defines.svh on the include path
// Notes:   option fields, pin samples and reset causes travel as packed structs
package eirq_pkg;
  `include "eirq_defines.svh"

  // option_config_register contents
  typedef struct packed {
    logic port_irq_merge_enable;
    logic level_sense;
  } eirq_opt_s;

  // synchronised pin samples
  typedef struct packed {
    logic                   irq_n;
    logic [`EIRQ_KBD_W-1:0] kbd;
  } eirq_pins_s;

  // internal reset causes
  typedef struct packed {
    logic watchdog_timeout;
    logic illegal_address;
    logic low_voltage;
  } eirq_rst_src_s;
endpackage

// [verif/eirq_far_side.sv]
// Purpose: far side model of interrupt pins, reset causes and reset wire
// Assumes: drive is called by the bench, changes land just after an edge
// Notes:   reset wire has a pull-up, open drain on both sides
`timescale 1ns/1ps
module eirq_far_side
  import eirq_pkg::*;
(
  // wire side
  input  wire logic     clk,
  input  wire logic     reset_pin_out,
  input  wire logic     reset_pin_oe_n,
  // pin drivers
  output logic          irq_pin_n,
  output logic [3:0]    kbd,
  output logic          reset_pin_in,
  output eirq_rst_src_s rst_src
);
  logic ext_low;
  // pull-up unless a party pulls low
  assign reset_pin_in = ~ext_low & (reset_pin_oe_n | reset_pin_out);
  initial begin
    irq_pin_n = 1'h1;
    kbd       = 4'h0;
    rst_src   = 3'h0;
    ext_low   = 1'h0;
  end
  task automatic drive(input logic i, input logic [3:0] k, input logic [2:0] s,
                       input logic e);
    @(posedge clk);
    irq_pin_n <= i;
    kbd       <= k;
    rst_src   <= s;
    ext_low   <= e;
  endtask
endmodule // eirq_far_side

// [verif/external_irq_and_reset_pin_tb_top.sv]
// Purpose: self-checking bench of the interrupt and reset pin block
// Assumes: zero wait apb slave, far side model drives the pins
// Notes:   expected values come from the rules at each step
`timescale 1ns/1ps
`include "eirq_defines.svh"
module external_irq_and_reset_pin_tb_top
  import eirq_pkg::*;
;
  logic          clk = 1'h0;
  logic          rst = 1'h1;
  logic          psel = 1'h0;
  logic          penable = 1'h0;
  logic          pwrite = 1'h0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, err, irq_n, rp_in, rp_out, rp_oe_n, cpu_irq, core_reset;
  logic [3:0]    kbd;
  eirq_rst_src_s src;
  int            n_fail = 0;
  int            n_tests = 0;
  int            cyc = 0;
  int            k;
  eirq_ctrl u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin_n(irq_n), .keyboard_irq_pins(kbd), .reset_pin_in(rp_in),
    .reset_pin_out(rp_out), .reset_pin_oe_n(rp_oe_n), .rst_src(src), .cpu_irq(cpu_irq),
    .core_reset(core_reset));
  eirq_far_side u_far (.clk(clk), .reset_pin_out(rp_out), .reset_pin_oe_n(rp_oe_n),
    .irq_pin_n(irq_n), .kbd(kbd), .reset_pin_in(rp_in), .rst_src(src));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(2321));
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    apb(0, `EIRQ_OFS_OPTION, 0);
    check(rd, 0, "option reset");
    apb(0, `EIRQ_OFS_CTRL, 0);
    check(rd, 32'h8, "ctrl reset");
    apb(0, 8'h10, 0);
    check(rd, 0, "unmapped read");
    check(err, 1, "unmapped error");
    $display("test registers done");
    u_far.drive(0, 0, 0, 0);
    settle();
    check(cpu_irq, 1, "falling edge");
    apb(1, `EIRQ_OFS_CTRL, 32'h2);
    settle();
    check(cpu_irq, 0, "edge only");
    u_far.drive(1, 0, 0, 0);
    apb(1, `EIRQ_OFS_CTRL, 32'h1);
    u_far.drive(0, 0, 0, 0);
    settle();
    check(cpu_irq, 0, "masked");
    apb(0, `EIRQ_OFS_CTRL, 0);
    check(rd, 32'h5, "flag under mask");
    apb(1, `EIRQ_OFS_CTRL, 32'h2);
    $display("test edge and mask done");
    u_far.drive(1, 0, 0, 0);
    apb(1, `EIRQ_OFS_OPTION, 32'h1);
    u_far.drive(0, 0, 0, 0);
    #1;
    check(cpu_irq, 1, "level path");
    apb(1, `EIRQ_OFS_CTRL, 32'h2);
    apb(0, `EIRQ_OFS_CTRL, 0);
    check(rd[2], 1, "level holds");
    u_far.drive(1, 0, 0, 0);
    apb(1, `EIRQ_OFS_CTRL, 32'h2);
    $display("test level done");
    apb(1, `EIRQ_OFS_OPTION, 32'h2);
    repeat (4) begin
      k = $urandom % 4;
      u_far.drive(1, 4'h1 << k, 0, 0);
      settle();
      check(cpu_irq, 1, "merged edge");
      u_far.drive(1, 0, 0, 0);
      apb(1, `EIRQ_OFS_CTRL, 32'h2);
      settle();
      check(cpu_irq, 0, "falling kbd");
    end
    apb(1, `EIRQ_OFS_OPTION, 0);
    u_far.drive(1, 4'h8, 0, 0);
    settle();
    check(cpu_irq, 0, "unmerged");
    apb(1, `EIRQ_OFS_OPTION, 32'h3);
    #1;
    check(cpu_irq, 1, "merged level");
    $display("test merge done");
    for (k = 0; k < 3; k++) begin
      u_far.drive(1, 0, 3'h1 << k, 0);
      #1;
      check({rp_oe_n, core_reset}, 1, "cause drives pin");
      u_far.drive(1, 0, 0, 0);
      #1;
      check(rp_oe_n, 0, "one cycle more");
      @(posedge clk);
      #1;
      check(rp_oe_n, 1, "released");
    end
    apb(0, `EIRQ_OFS_OPTION, 0);
    check(rd, 0, "options reset");
    u_far.drive(1, 0, 0, 1);
    #1;
    check({rp_oe_n, core_reset}, 3, "outside reset");
    u_far.drive(1, 0, 0, 0);
    #1;
    check(core_reset, 0, "reset ends");
    $display("test reset pin done");
    summarize();
  end
endmodule // external_irq_and_reset_pin_tb_top
